// *** hdl/cca_channel.v ***
// One capture/compare module: mode, value, auto-reload, flag and pin.
// Assumes write strobes are already decoded and gated by the parent.
`timescale 1ns/100ps
`default_nettype none
`include "cca_defines.vh"

module cca_channel (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Counter
    input  wire [15:0] count,
    input  wire        tick,
    // Register writes
    input  wire [7:0]  wdata,
    input  wire        wr_mode,
    input  wire        wr_low,
    input  wire        wr_high,
    input  wire        auto_reload_select,
    input  wire [1:0]  wsel,
    input  wire        flag_clr,
    // Capture edges
    input  wire        cap_rise,
    input  wire        cap_fall,
    // State
    output reg  [7:0]  mode_reg,
    output wire [7:0]  rd_low,
    output wire [7:0]  rd_high,
    output reg         flag_reg,
    output reg         pin_reg
);

    reg  [15:0] value_reg;
    reg  [15:0] reload_reg;
    reg  [15:0] mask;
    reg         flag_set;
    wire        s16   = mode_reg[`CCA_MODE_S16];
    wire        ecom  = mode_reg[`CCA_MODE_ECOM];
    wire        pm    = mode_reg[`CCA_MODE_PM];
    wire        tog   = mode_reg[`CCA_MODE_TOG];
    wire        freq  = pm & tog;
    wire        match = tick & ecom & (count == value_reg);
    wire        fmatch = tick & ecom & (count[7:0] == value_reg[7:0]);
    wire        wrap  = tick & ((count & mask) == mask);
    wire        capt  = (cap_rise & mode_reg[`CCA_MODE_CAPP]) |
                        (cap_fall & mode_reg[`CCA_MODE_CAPN]);

    assign rd_low  = auto_reload_select ? reload_reg[7:0]  : value_reg[7:0]; // RL12
    assign rd_high = auto_reload_select ? reload_reg[15:8] : value_reg[15:8]; // RL12

    always @* begin
        if (s16) begin
            mask = `CCA_MASK_16; // RL2
        end else begin
            case (wsel)
                2'd0:    mask = `CCA_MASK_8;
                2'd1:    mask = `CCA_MASK_9;
                2'd2:    mask = `CCA_MASK_10;
                default: mask = `CCA_MASK_11;
            endcase
        end
        flag_set = capt | (match & mode_reg[`CCA_MODE_MAT]);
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg   <= `CCA_RST_BYTE;
            value_reg  <= `CCA_RST_WORD;
            reload_reg <= `CCA_RST_WORD;
            flag_reg   <= 1'b0;
            pin_reg    <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_reg <= wdata;
            end
            // Reload happens before bus writes so software wins
            if (pm && !freq && !s16 && wrap) begin
                if (wsel == 2'd0) begin
                    value_reg[7:0] <= value_reg[15:8];
                end else begin
                    value_reg <= (value_reg & ~mask) |
                                 (reload_reg & mask); // RL11
                end
            end
            if (freq && fmatch) begin
                value_reg[7:0] <= value_reg[7:0] + value_reg[15:8]; // RL3
            end
            if (capt) begin
                value_reg <= count;
            end
            if (wr_low) begin
                if (auto_reload_select) begin
                    reload_reg[7:0] <= wdata; // RL11
                end else begin
                    value_reg[7:0]            <= wdata; // RL10
                    mode_reg[`CCA_MODE_ECOM] <= 1'b0; // RL13
                end
            end
            if (wr_high) begin
                if (auto_reload_select) begin
                    reload_reg[15:8] <= wdata; // RL11
                end else begin
                    value_reg[15:8]           <= wdata; // RL10
                    mode_reg[`CCA_MODE_ECOM] <= 1'b1; // RL14
                end
            end
            // Hardware set beats a same-cycle clear
            if (flag_set) begin
                flag_reg <= 1'b1;
            end else if (flag_clr) begin
                flag_reg <= 1'b0;
            end
            if (freq) begin
                if (fmatch) begin
                    pin_reg <= ~pin_reg; // RL3
                end
            end else if (pm) begin
                pin_reg <= ecom &
                           ((count & mask) >= (value_reg & mask)); // RL1 RL2
            end else if (tog && match) begin
                pin_reg <= ~pin_reg;
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/cca_regs.v ***
// Register side of the counter array: counter, snapshot, three modules.
// Assumes a single-cycle SFR bus; read data appears one clock after SFR_RD.
`timescale 1ns/100ps
`default_nettype none
`include "cca_defines.vh"

// Notes on behaviour
// RL1 - Pulse mode drives modulated wave on pin
// RL2 - Select bit picks 8-11 or 16-bit resolution
// RL3 - Pulse plus toggle gives frequency output
// RL4 - Flag requests interrupt only when enabled
// RL5 - Watchdog locks module 5 mode register
// RL6 - Watchdog blocks counter low byte writes
// RL7 - Watchdog blocks counter high byte writes
// RL8 - Sixteen-bit counter, two byte addresses
// RL9 - High byte reads snapshot taken on low read
// RL10 - Each module holds sixteen-bit value bytes
// RL11 - Reload value reachable in 9-11 bit mode
// RL12 - Reload select steers value byte accesses
// RL13 - Low value write clears comparator enable
// RL14 - High value write sets comparator enable
// RL15 - Locked writes vanish without side effects
// RL16 - Software reads low byte before high
module cca_regs #(
    parameter NMOD = 3
) (
    // Clock and reset
    input  wire            CLOCK,
    input  wire            RST_N,
    // SFR bus
    input  wire [7:0]      SFR_ADDR,
    input  wire            SFR_WR,
    input  wire            SFR_RD,
    input  wire [7:0]      SFR_WDATA,
    output reg  [7:0]      SFR_RDATA,
    // Module pins
    input  wire [NMOD-1:0] CAPTURE_IN,
    output reg  [NMOD-1:0] MODULE_OUTPUT_PIN,
    // Events
    output reg             IRQ,
    output reg             WDT_TIMEOUT
);

    // ======================================
    // Address decode
    function [NMOD-1:0] dec_low;
        input [7:0] a;
        begin
            dec_low = {a == `CCA_ADDR_MOD2_LO,
                       a == `CCA_ADDR_MOD1_LO,
                       a == `CCA_ADDR_MOD0_LO};
        end
    endfunction

    function [NMOD-1:0] dec_high;
        input [7:0] a;
        begin
            dec_high = {a == `CCA_ADDR_MOD2_HI,
                        a == `CCA_ADDR_MOD1_HI,
                        a == `CCA_ADDR_MOD0_HI};
        end
    endfunction

    function [NMOD-1:0] dec_mode;
        input [7:0] a;
        begin
            dec_mode = {a == `CCA_ADDR_MODE2,
                        a == `CCA_ADDR_MODE1,
                        a == `CCA_ADDR_MODE0};
        end
    endfunction

    // ======================================
    // Registers
    reg  [15:0]     count_reg;
    reg  [7:0]      snap_reg;
    reg  [7:0]      ctrl_reg;
    reg  [7:0]      pmctl_reg;
    reg  [7:0]      mode5_reg;
    reg  [NMOD-1:0] cap_prev_reg;
    reg  [7:0]      rdata_next;

    wire [NMOD-1:0] cap_sync;
    wire [NMOD-1:0] wr_low   = {NMOD{SFR_WR}} & dec_low(SFR_ADDR);
    wire [NMOD-1:0] wr_high  = {NMOD{SFR_WR}} & dec_high(SFR_ADDR);
    wire [NMOD-1:0] wr_mode  = {NMOD{SFR_WR}} & dec_mode(SFR_ADDR);
    wire            wr_stat  = SFR_WR & (SFR_ADDR == `CCA_ADDR_STATUS);
    wire            watchdog_enable     = ctrl_reg[`CCA_CTRL_WATCHDOG_ENABLE];
    wire            auto_reload_select    = pmctl_reg[`CCA_PM_AUTO_RELOAD_SELECT];
    wire [1:0]      wsel     = pmctl_reg[`CCA_PM_WSEL_HI:`CCA_PM_WSEL_LO];
    wire            tick     = ctrl_reg[`CCA_CTRL_RUN];
    // Locked writes are dropped here, before any side effect
    wire            wr_cnt_lo = SFR_WR & !watchdog_enable &
                                (SFR_ADDR == `CCA_ADDR_CNT_LO); // RL6 RL15
    wire            wr_cnt_hi = SFR_WR & !watchdog_enable &
                                (SFR_ADDR == `CCA_ADDR_CNT_HI); // RL7 RL15
    wire            wr_mode5  = SFR_WR & !watchdog_enable &
                                (SFR_ADDR == `CCA_ADDR_MODE5); // RL5 RL15
    wire            rd_cnt_lo = SFR_RD & (SFR_ADDR == `CCA_ADDR_CNT_LO);

    wire [8*NMOD-1:0] mode_bus;
    wire [8*NMOD-1:0] low_bus;
    wire [8*NMOD-1:0] high_bus;
    wire [NMOD-1:0]   flag_bus;
    wire [NMOD-1:0]   pin_bus;
    wire [NMOD-1:0]   irq_bus;

    // ======================================
    // Capture pin synchronisers
    cca_sync #(
        .W (NMOD)
    ) u_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     (CAPTURE_IN),
        .q     (cap_sync)
    );

    // ======================================
    // Capture/compare modules
    genvar g;
    generate
        for (g = 0; g < NMOD; g = g + 1) begin : g_mod
            cca_channel u_chan (
                .clk      (CLOCK),
                .rst_n    (RST_N),
                .count    (count_reg),
                .tick     (tick),
                .wdata    (SFR_WDATA),
                .wr_mode  (wr_mode[g]),
                .wr_low   (wr_low[g]),
                .wr_high  (wr_high[g]),
                .auto_reload_select    (auto_reload_select),
                .wsel     (wsel),
                .flag_clr (wr_stat & !SFR_WDATA[g]),
                .cap_rise (cap_sync[g] & !cap_prev_reg[g]),
                .cap_fall (!cap_sync[g] & cap_prev_reg[g]),
                .mode_reg (mode_bus[8*g+7:8*g]),
                .rd_low   (low_bus[8*g+7:8*g]),
                .rd_high  (high_bus[8*g+7:8*g]),
                .flag_reg (flag_bus[g]),
                .pin_reg  (pin_bus[g])
            );
            assign irq_bus[g] = flag_bus[g] &
                                mode_bus[8*g+`CCA_MODE_IRQEN]; // RL4
        end
    endgenerate

    // ======================================
    // Counter, snapshot and control
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            count_reg    <= `CCA_RST_WORD;
            snap_reg     <= `CCA_RST_BYTE;
            ctrl_reg     <= `CCA_RST_CTRL;
            pmctl_reg    <= `CCA_RST_BYTE;
            mode5_reg    <= `CCA_RST_BYTE;
            cap_prev_reg <= {NMOD{1'b0}};
            WDT_TIMEOUT  <= 1'b0;
        end else begin
            cap_prev_reg <= cap_sync;
            if (tick) begin
                count_reg <= count_reg + 16'h0001;
            end
            if (wr_cnt_lo) begin
                count_reg[7:0] <= SFR_WDATA; // RL8 RL6
            end
            if (wr_cnt_hi) begin
                count_reg[15:8] <= SFR_WDATA; // RL8 RL7
            end
            // Reading the low byte freezes the high byte for coherence
            if (rd_cnt_lo) begin
                snap_reg <= count_reg[15:8]; // RL9
            end
            if (SFR_WR && SFR_ADDR == `CCA_ADDR_CTRL) begin
                ctrl_reg <= SFR_WDATA;
            end
            if (SFR_WR && SFR_ADDR == `CCA_ADDR_PMCTL) begin
                pmctl_reg <= SFR_WDATA;
            end
            if (wr_mode5) begin
                mode5_reg <= SFR_WDATA; // RL5
            end
            // Module 5 serves as watchdog: expiry on counter wrap
            WDT_TIMEOUT <= watchdog_enable & tick & (count_reg == 16'hffff); // RL5
        end
    end

    // ======================================
    // Read path
    always @* begin
        rdata_next = 8'h00;
        case (SFR_ADDR)
            `CCA_ADDR_CNT_LO:  rdata_next = count_reg[7:0]; // RL8
            `CCA_ADDR_CNT_HI:  rdata_next = snap_reg; // RL9
            `CCA_ADDR_MOD0_LO: rdata_next = low_bus[7:0];
            `CCA_ADDR_MOD0_HI: rdata_next = high_bus[7:0];
            `CCA_ADDR_MOD1_LO: rdata_next = low_bus[15:8];
            `CCA_ADDR_MOD1_HI: rdata_next = high_bus[15:8];
            `CCA_ADDR_MOD2_LO: rdata_next = low_bus[23:16];
            `CCA_ADDR_MOD2_HI: rdata_next = high_bus[23:16];
            `CCA_ADDR_MODE0:   rdata_next = mode_bus[7:0];
            `CCA_ADDR_MODE1:   rdata_next = mode_bus[15:8];
            `CCA_ADDR_MODE2:   rdata_next = mode_bus[23:16];
            `CCA_ADDR_MODE5:   rdata_next = mode5_reg;
            `CCA_ADDR_CTRL:    rdata_next = ctrl_reg;
            `CCA_ADDR_PMCTL:   rdata_next = pmctl_reg;
            `CCA_ADDR_STATUS:  rdata_next = {{(8-NMOD){1'b0}}, flag_bus};
            default:           rdata_next = 8'h00;
        endcase
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            SFR_RDATA         <= 8'h00;
            MODULE_OUTPUT_PIN <= {NMOD{1'b0}};
            IRQ               <= 1'b0;
        end else begin
            if (SFR_RD) begin
                SFR_RDATA <= rdata_next;
            end
            MODULE_OUTPUT_PIN <= pin_bus; // RL1
            IRQ               <= |irq_bus; // RL4
        end
    end

endmodule
`default_nettype wire

// *** hdl/cca_sync.v ***
// Two-stage synchroniser for a vector of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module cca_sync #(
    parameter W = 3
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// *** include/cca_defines.vh ***
// Constants for the counter array register block.
// Assumes an 8-bit special-function-register bus with byte addresses.
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH

// ======================================
// Register byte addresses
`define CCA_ADDR_MOD1_LO   8'he9
`define CCA_ADDR_MOD1_HI   8'hea
`define CCA_ADDR_MOD2_LO   8'heb
`define CCA_ADDR_MOD2_HI   8'hec
`define CCA_ADDR_CNT_LO    8'hf9
`define CCA_ADDR_CNT_HI    8'hfa
`define CCA_ADDR_MOD0_LO   8'hfb
`define CCA_ADDR_MOD0_HI   8'hfc
`define CCA_ADDR_CTRL      8'hd8
`define CCA_ADDR_MODE0     8'hd9
`define CCA_ADDR_MODE1     8'hda
`define CCA_ADDR_MODE2     8'hdb
`define CCA_ADDR_PMCTL     8'hdc
`define CCA_ADDR_MODE5     8'hdd
`define CCA_ADDR_STATUS    8'hde

// ======================================
// Reset values
`define CCA_RST_BYTE       8'h00
`define CCA_RST_WORD       16'h0000
`define CCA_RST_CTRL       8'h00

// ======================================
// Control register fields
`define CCA_CTRL_RUN       0
`define CCA_CTRL_WATCHDOG_ENABLE      6

// ======================================
// Pulse modulation control fields
`define CCA_PM_AUTO_RELOAD_SELECT       6
`define CCA_PM_WSEL_HI     1
`define CCA_PM_WSEL_LO     0

// ======================================
// Module mode register fields
`define CCA_MODE_S16       7
`define CCA_MODE_ECOM      6
`define CCA_MODE_CAPP      5
`define CCA_MODE_CAPN      4
`define CCA_MODE_MAT       3
`define CCA_MODE_TOG       2
`define CCA_MODE_PM        1
`define CCA_MODE_IRQEN     0

// ======================================
// Pulse modulation resolution masks
`define CCA_MASK_8         16'h00ff
`define CCA_MASK_9         16'h01ff
`define CCA_MASK_10        16'h03ff
`define CCA_MASK_11        16'h07ff
`define CCA_MASK_16        16'hffff

`endif

// *** tb/cca_pin_model.sv ***
// Model of the circuitry that faces the capture pins.
// Assumes the bench sets the wanted pin levels after a clock edge.
`timescale 1ns/100ps
`default_nettype none

module cca_pin_model (
    // Clock
    input  wire logic       clk,
    // Wanted levels
    input  wire logic [2:0] level,
    // Capture pins
    output var logic  [2:0] cap
);
    // ======================================
    // Pin drive
    initial cap = 3'h0;
    // Late change keeps pin edges clear of the sampling edge
    always @(posedge clk) begin
        cap <= #2 level;
    end
endmodule

`default_nettype wire

// *** tb/cca_regs_chk.sv ***
// Port-level checker for the counter array register block.
// Assumes it is bound to cca_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module cca_regs_chk #(
    parameter NMOD = 3
) (
    // Watched ports
    input wire logic            CLOCK,
    input wire logic            RST_N,
    input wire logic [7:0]      SFR_ADDR,
    input wire logic            SFR_WR,
    input wire logic            SFR_RD,
    input wire logic [7:0]      SFR_WDATA,
    input wire logic [7:0]      SFR_RDATA,
    input wire logic [NMOD-1:0] CAPTURE_IN,
    input wire logic [NMOD-1:0] MODULE_OUTPUT_PIN,
    input wire logic            IRQ,
    input wire logic            WDT_TIMEOUT
);
    // ======================================
    // Shadow of the control state
    logic       wd_reg;
    logic       ar_reg;
    logic [2:1] en_reg;
    logic [7:0] m0_reg;
    logic [7:0] m5_reg;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            {wd_reg, ar_reg, en_reg, m0_reg, m5_reg} <= '0;
        end else if (SFR_WR) begin
            case (SFR_ADDR)
                8'hd8: wd_reg <= SFR_WDATA[6];
                8'hd9: m0_reg <= SFR_WDATA;
                8'hda: en_reg[1] <= SFR_WDATA[0];
                8'hdb: en_reg[2] <= SFR_WDATA[0];
                8'hdc: ar_reg <= SFR_WDATA[6];
                8'hdd: if (!wd_reg) m5_reg <= SFR_WDATA;
                8'hfb: if (!ar_reg) m0_reg[6] <= 1'b0;
                8'hfc: if (!ar_reg) m0_reg[6] <= 1'b1;
                default: ;
            endcase
        end
    end

    // ======================================
    // Sequences
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence seq_rd_hi;
        SFR_RD && SFR_ADDR == 8'hfa;
    endsequence
    sequence seq_irq_off;
        ({en_reg, m0_reg[0]} == 3'b000) [*2];
    endsequence
    sequence seq_pin_off;
        (m0_reg[2:1] == 2'b00) [*3];
    endsequence

    // ======================================
    // Assertions
    AST_RD_HOLD:
        assert property (!SFR_RD |=> $stable(SFR_RDATA))
        else $error("read data moved without a read");
    AST_SNAP_HOLD:
        assert property (seq_rd_hi ##1 seq_rd_hi |=> $stable(SFR_RDATA))
        else $error("high byte changed without a low read");
    AST_IRQ_MASK:
        assert property (seq_irq_off |-> !IRQ)
        else $error("interrupt raised while all masked");
    AST_WDT_GATE:
        assert property (WDT_TIMEOUT |-> wd_reg || $past(wd_reg))
        else $error("timeout while watchdog off");
    AST_WDT_PULSE:
        assert property (WDT_TIMEOUT |=> !WDT_TIMEOUT)
        else $error("timeout longer than one cycle");
    AST_PIN_IDLE:
        assert property (seq_pin_off |-> $stable(MODULE_OUTPUT_PIN[0]))
        else $error("pin moved with modulation and toggle off");
    AST_MODE5_LOCK:
        assert property (SFR_RD && SFR_ADDR == 8'hdd
                         |=> SFR_RDATA == $past(m5_reg))
        else $error("locked mode register changed");
    AST_MODE0_ECOM:
        assert property (SFR_RD && SFR_ADDR == 8'hd9
                         |=> SFR_RDATA == $past(m0_reg))
        else $error("mode register or comparator enable wrong");
endmodule

bind cca_regs cca_regs_chk #(.NMOD(NMOD)) u_cca_regs_chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .CAPTURE_IN(CAPTURE_IN),
    .MODULE_OUTPUT_PIN(MODULE_OUTPUT_PIN), .IRQ(IRQ),
    .WDT_TIMEOUT(WDT_TIMEOUT)
);

`default_nettype wire

// *** tb/cca_regs_tb_top.sv ***
// Self-checking bench for the counter array register block.
// Assumes the pin model drives the capture pins.
`timescale 1ns/100ps
`default_nettype none

module cca_regs_tb_top;
    // ======================================
    // Signals
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [2:0] lvl = 3'h0;
    wire  [7:0] rdata;
    wire  [2:0] cap;
    wire  [2:0] pin;
    wire        irq;
    wire        wdt;
    int         n_fail = 0;
    int         checked = 0;
    int         k;
    int         t;
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] va [6] = '{8'hfb, 8'hfc, 8'he9, 8'hea, 8'heb, 8'hec};

    cca_regs u_cca_regs (
        .CLOCK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .CAPTURE_IN(cap), .MODULE_OUTPUT_PIN(pin), .IRQ(irq),
        .WDT_TIMEOUT(wdt)
    );
    cca_pin_model u_cca_pin_model (.clk(clk), .level(lvl), .cap(cap));

    initial forever #2.5 clk = ~clk;

    // ======================================
    // Tasks
    task automatic check(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr8(input logic [7:0] a, dt);
        @(posedge clk);
        #1 {addr, wdata, wr} = {a, dt, 1'b1};
        @(posedge clk);
        #1 wr = 1'b0;
    endtask
    // Holds the strobe n cycles; returns the last answer
    task automatic rd8(input logic [7:0] a, input int n,
                       output logic [7:0] q);
        @(posedge clk);
        #1 {addr, rd} = {a, 1'b1};
        repeat (n) @(posedge clk);
        #1 rd = 1'b0;
        q = rdata;
    endtask
    task automatic count_pin(input int n, output int hi, tg);
        logic p;
        p = pin[0];
        {hi, tg} = '0;
        repeat (n) begin
            @(posedge clk);
            #1 hi += pin[0];
            tg += (pin[0] != p);
            p = pin[0];
        end
    endtask
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ======================================
    // Sequence
    initial begin
        #400000;
        n_fail++;
        final_report();
    end

    initial begin
        t = $urandom(57);
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        rd8(8'hfa, 1, d);
        check("count reset", d, 8'h00);
        for (k = 0; k < 6; k++) begin
            rd8(va[k], 1, d);
            check("value reset", d, 8'h00);
            v = 8'($urandom);
            wr8(va[k], v);
            rd8(va[k], 1, d);
            check("value rw", d, v);
        end
        v = 8'($urandom);
        w = 8'($urandom);
        wr8(8'hf9, v);
        wr8(8'hfa, w);
        rd8(8'hf9, 1, d);
        check("count low", d, v);
        wr8(8'hfa, ~w);
        rd8(8'hfa, 2, d);
        check("snapshot", d, w);
        // Locked writes must leave no trace
        wr8(8'hd8, 8'h40);
        wr8(8'hf9, ~v);
        wr8(8'hfa, 8'h5a);
        wr8(8'hdd, 8'h3c);
        rd8(8'hdd, 1, d);
        check("mode5 locked", d, 8'h00);
        wr8(8'hd8, 8'h00);
        rd8(8'hf9, 1, d);
        check("locked low", d, v);
        rd8(8'hfa, 1, d);
        check("locked high", d, ~w);
        wr8(8'hdd, 8'h3c);
        rd8(8'hdd, 1, d);
        check("mode5 free", d, 8'h3c);
        wr8(8'hd9, 8'h40);
        wr8(8'hfb, v);
        rd8(8'hd9, 1, d);
        check("ecom clear", d, 8'h00);
        wr8(8'hfc, w);
        rd8(8'hd9, 1, d);
        check("ecom set", d, 8'h40);
        wr8(8'hdc, 8'h41);
        wr8(8'hfb, ~v);
        rd8(8'hd9, 1, d);
        check("reload no ecom", d, 8'h40);
        rd8(8'hfb, 1, d);
        check("reload low", d, ~v);
        wr8(8'hdc, 8'h01);
        rd8(8'hfb, 1, d);
        check("value low", d, v);
        // Wrap close to the top with the watchdog on
        wr8(8'hf9, 8'he0);
        wr8(8'hfa, 8'hff);
        wr8(8'hd8, 8'h41);
        for (t = 0; t < 40 && wdt !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        check("wdt timeout", {7'h0, wdt}, 8'h01);
        wr8(8'hd8, 8'h00);
        v = 8'(1 + $urandom_range(254));
        wr8(8'hd9, 8'h42);
        wr8(8'hdc, 8'h00);
        wr8(8'hfb, v);
        wr8(8'hfc, v);
        wr8(8'hd8, 8'h01);
        repeat (300) @(posedge clk);
        count_pin(512, k, t);
        check("pwm duty", 8'(k / 2), 8'(256 - v));
        v = 8'(2 + $urandom_range(30));
        wr8(8'hd9, 8'h46);
        wr8(8'hfb, 8'h00);
        wr8(8'hfc, v);
        repeat (300) @(posedge clk);
        count_pin(8 * v, k, t);
        check("freq toggles", 8'(t), 8'h08);
        wr8(8'hd8, 8'h00);
        // Sixteen-bit compare must use the high byte too
        wr8(8'hd9, 8'h82);
        wr8(8'hfb, 8'h00);
        wr8(8'hfc, 8'h80);
        wr8(8'hf9, 8'hff);
        wr8(8'hfa, 8'h7f);
        repeat (3) @(posedge clk);
        #1 check("pwm16 below", {7'h0, pin[0]}, 8'h00);
        wr8(8'hfa, 8'h80);
        repeat (3) @(posedge clk);
        #1 check("pwm16 above", {7'h0, pin[0]}, 8'h01);
        wr8(8'hd9, 8'h20);
        wr8(8'hde, 8'h00);
        lvl = 3'h1;
        repeat (8) @(posedge clk);
        #1 check("irq masked", {7'h0, irq}, 8'h00);
        rd8(8'hde, 1, d);
        check("flag", d & 8'h01, 8'h01);
        wr8(8'hd9, 8'h21);
        repeat (3) @(posedge clk);
        #1 check("irq raised", {7'h0, irq}, 8'h01);
        final_report();
    end
endmodule

`default_nettype wire
